/* File: include/jesd_rx_cfg_pkg.sv */
// Constants and types shared by the receive release and sync configuration block
package jesd_rx_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] SYNC_HEADER_MODE_ADDR = 12'h104;
  localparam logic [11:0] FRAMES_PER_MF_ADDR = 12'h105;
  localparam logic [11:0] RELEASE_DELAY_ADDR = 12'h106;
  localparam logic [11:0] LINK_STATUS_ADDR = 12'h107;
  localparam logic [1:0] SYNC_HEADER_MODE_RST = 2'h0;
  localparam logic [7:0] FRAMES_PER_MF_RST = 8'h1f;
  localparam logic [5:0] RELEASE_DELAY_RST = 6'h00;
  localparam logic [1:0] SYNC_MODE_CRC12 = 2'h0;
  localparam int SYNC_MODE_LSB = 0;
  localparam int SYNC_MODE_W = 2;
  localparam int RELEASE_DELAY_W = 6;
  localparam int STATUS_ELASTIC_BUFFER_ERROR_FLAG_BIT = 7;
  localparam int STATUS_LINK_UP_BIT = 6;
  localparam logic ENC_8B10B = 1'b0;
  localparam logic ENC_64B66B = 1'b1;
  localparam int OCTETS_PER_DELAY_STEP = 4;
  localparam logic [15:0] OCTETS_PER_MULTIBLOCK = 16'h0100;
  localparam int MF_W = 16;

  typedef struct packed {
    logic [1:0] sync_header_mode;
    logic [7:0] frames_per_multiframe_less_one;
    logic [5:0] release_buffer_delay;
  } cfg_t;

  typedef enum logic [1:0] {
    REL_IDLE = 2'b00,
    REL_WAIT_MF = 2'b01,
    REL_COUNT = 2'b10,
    REL_UP = 2'b11
  } rel_state_t;
endpackage

/* File: rtl/jesd_rx_release_sync_cfg.sv */
// Receive sync-word mode, multiframe length and elastic buffer release control
// Notes on behaviour
// - Mode field bits 1-0, reset 0 selects CRC-12 checking; 1-3 reserved.
// - Sync word holds 32 data bits; mode applies only under 64b/66b.
// - No command channel; all command fields of sync words are ignored.
// - Under 8b/10b the 8-bit field is multiframe length in frames less one.
// - Frames-per-multiframe resets to 31, thirty-two frames per multiframe.
// - Under 64b/66b the field is ignored; length is 256*E/F frames.
// - Six-bit release delay, reset 0, each step delays release four octets.
// - Encoding select 0 is 8b/10b, 1 is 64b/66b; it picks what applies.
// - Subclass 0 releases once lanes write; subclass 1 at delayed opportunity.
// - Buffer under or overflow sets a sticky flag cleared by writing one.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module jesd_rx_release_sync_cfg
  import jesd_rx_cfg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rd_data_o,
  input wire logic link_encoding_select_i,
  input wire logic subclass_i,
  input wire logic serial_link_enable_i,
  input wire logic [7:0] octets_per_frame_i,
  input wire logic [4:0] multiblocks_per_emb_i,
  input wire logic all_lanes_writing_i,
  input wire logic mf_boundary_i,
  input wire logic quad_octet_tick_i,
  input wire logic eb_fault_i,
  output logic crc12_check_en_o,
  output logic sync_mode_reserved_o,
  output logic [MF_W-1:0] multiframe_frames_o,
  output logic buffer_release_o,
  output logic elastic_buffer_error_flag_o
);
  cfg_t cfg, next_cfg;
  logic elastic_buffer_error_flag, next_elastic_buffer_error_flag;
  logic [DATA_W-1:0] next_rd_data;
  rel_state_t state, next_state;
  logic [RELEASE_DELAY_W-1:0] cnt, next_cnt;
  logic crc_en, next_crc_en, mode_rsv, next_mode_rsv;
  logic [MF_W-1:0] mf_len, next_mf_len;
  logic up;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  // Register writes and status flag
  always_comb begin
    next_cfg = cfg;
    next_elastic_buffer_error_flag = elastic_buffer_error_flag;
    if (wr_i && hit(addr_i, SYNC_HEADER_MODE_ADDR)) begin
      next_cfg.sync_header_mode = wr_data_i[SYNC_MODE_LSB +: SYNC_MODE_W];
    end
    if (wr_i && hit(addr_i, FRAMES_PER_MF_ADDR)) begin
      next_cfg.frames_per_multiframe_less_one = wr_data_i;
    end
    if (wr_i && hit(addr_i, RELEASE_DELAY_ADDR)) begin
      next_cfg.release_buffer_delay = wr_data_i[RELEASE_DELAY_W-1:0];
    end
    if (wr_i && hit(addr_i, LINK_STATUS_ADDR) && wr_data_i[STATUS_ELASTIC_BUFFER_ERROR_FLAG_BIT]) begin
      next_elastic_buffer_error_flag = 1'b0;
    end
    // A fault in the clearing cycle still sets the flag
    if (eb_fault_i) begin
      next_elastic_buffer_error_flag = 1'b1;
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads return zero
  always_comb begin
    next_rd_data = '0;
    if (rd_i) begin
      if (hit(addr_i, SYNC_HEADER_MODE_ADDR)) begin
        next_rd_data[SYNC_MODE_LSB +: SYNC_MODE_W] = cfg.sync_header_mode;
      end else if (hit(addr_i, FRAMES_PER_MF_ADDR)) begin
        next_rd_data = cfg.frames_per_multiframe_less_one;
      end else if (hit(addr_i, RELEASE_DELAY_ADDR)) begin
        next_rd_data[RELEASE_DELAY_W-1:0] = cfg.release_buffer_delay;
      end else if (hit(addr_i, LINK_STATUS_ADDR)) begin
        next_rd_data[STATUS_ELASTIC_BUFFER_ERROR_FLAG_BIT] = elastic_buffer_error_flag;
        next_rd_data[STATUS_LINK_UP_BIT] = up;
      end
    end
  end

  // Derived link settings; command fields never enter this block
  always_comb begin
    next_crc_en = (link_encoding_select_i == ENC_64B66B) &&
                  (cfg.sync_header_mode == SYNC_MODE_CRC12);
    next_mode_rsv = (link_encoding_select_i == ENC_64B66B) &&
                    (cfg.sync_header_mode != SYNC_MODE_CRC12);
    if (link_encoding_select_i == ENC_8B10B) begin
      next_mf_len = {8'h00, cfg.frames_per_multiframe_less_one} + 16'h0001;
    end else if (octets_per_frame_i == 8'h00) begin
      // Divide by zero guard; a zero frame size is never a legal setting
      next_mf_len = '0;
    end else begin
      next_mf_len = (OCTETS_PER_MULTIBLOCK * {11'h000, multiblocks_per_emb_i}) /
                    {8'h00, octets_per_frame_i};
    end
  end

  // Elastic buffer release sequencing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      REL_IDLE: begin
        next_cnt = '0;
        if (all_lanes_writing_i) begin
          next_state = subclass_i ? REL_WAIT_MF : REL_UP;
        end
      end
      REL_WAIT_MF: begin
        next_cnt = '0;
        if (mf_boundary_i) begin
          next_state = REL_COUNT;
        end
      end
      REL_COUNT: begin
        // One delay step is one group of four octets past the boundary
        if (cnt == cfg.release_buffer_delay) begin
          next_state = REL_UP;
        end else if (quad_octet_tick_i) begin
          next_cnt = cnt + 6'h01;
        end
      end
      REL_UP: begin
        next_cnt = '0;
      end
    endcase
    if (!serial_link_enable_i) begin
      next_state = REL_IDLE;
      next_cnt = '0;
    end
  end

  assign up = (state == REL_UP);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg.sync_header_mode <= SYNC_HEADER_MODE_RST;
      cfg.frames_per_multiframe_less_one <= FRAMES_PER_MF_RST;
      cfg.release_buffer_delay <= RELEASE_DELAY_RST;
      elastic_buffer_error_flag <= 1'b0;
      rd_data_o <= '0;
      state <= REL_IDLE;
      cnt <= '0;
      crc_en <= 1'b0;
      mode_rsv <= 1'b0;
      mf_len <= '0;
    end else if (ce_i) begin
      cfg <= next_cfg;
      elastic_buffer_error_flag <= next_elastic_buffer_error_flag;
      rd_data_o <= next_rd_data;
      state <= next_state;
      cnt <= next_cnt;
      crc_en <= next_crc_en;
      mode_rsv <= next_mode_rsv;
      mf_len <= next_mf_len;
    end
  end

  assign crc12_check_en_o = crc_en;
  assign sync_mode_reserved_o = mode_rsv;
  assign multiframe_frames_o = mf_len;
  assign buffer_release_o = up;
  assign elastic_buffer_error_flag_o = elastic_buffer_error_flag;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  crc_mode_sel_a: assert property (ce_i && link_encoding_select_i == ENC_8B10B |=> !crc_en)
    else $error("CRC check enabled under 8b/10b");
  crc_enable_a: assert property (
    ce_i && link_encoding_select_i && cfg.sync_header_mode == SYNC_MODE_CRC12
    |=> crc_en && !mode_rsv)
    else $error("CRC-12 not selected by mode zero");
  mode_rsv_a: assert property (
    ce_i && link_encoding_select_i && cfg.sync_header_mode != SYNC_MODE_CRC12
    |=> mode_rsv && !crc_en)
    else $error("Reserved sync mode not flagged");
  frames_write_a: assert property (
    ce_i && wr_i && addr_i == FRAMES_PER_MF_ADDR
    |=> cfg.frames_per_multiframe_less_one == $past(wr_data_i))
    else $error("Frames field write lost");
  mf_len_8b_a: assert property (
    ce_i && !link_encoding_select_i
    |=> mf_len == $past(cfg.frames_per_multiframe_less_one) + 16'h0001)
    else $error("Multiframe length not field plus one");
  mf_reset_a: assert property (
    $fell(rst_i) |-> cfg.frames_per_multiframe_less_one == FRAMES_PER_MF_RST)
    else $error("Frames field reset value wrong");
  mf_len_64b_a: assert property (
    ce_i && link_encoding_select_i && octets_per_frame_i == 8'h01
    |=> mf_len == {3'h0, $past(multiblocks_per_emb_i), 8'h00})
    else $error("64b/66b multiframe length wrong");
  sc0_release_a: assert property (
    ce_i && state == REL_IDLE && all_lanes_writing_i && !subclass_i &&
    serial_link_enable_i |=> up)
    else $error("Subclass 0 release missed");
  // Subclass 1 must never take the immediate path, even with a zero delay
  sc1_wait_a: assert property (
    ce_i && state == REL_IDLE && all_lanes_writing_i && subclass_i && serial_link_enable_i
    |=> !up)
    else $error("Subclass 1 released without an opportunity");
  rel_drop_a: assert property (ce_i && !serial_link_enable_i |=> !up)
    else $error("Release held with link disabled");
  sc1_delay_a: assert property (
    state == REL_COUNT && cnt != cfg.release_buffer_delay |=> !up)
    else $error("Release before delay elapsed");
  delay_step_a: assert property (
    ce_i && serial_link_enable_i && state == REL_COUNT && quad_octet_tick_i &&
    cnt != cfg.release_buffer_delay |=> cnt == $past(cnt) + 6'h01)
    else $error("Release delay step not counted");
  eb_clear_a: assert property (
    ce_i && wr_i && addr_i == LINK_STATUS_ADDR && wr_data_i[STATUS_ELASTIC_BUFFER_ERROR_FLAG_BIT] && !eb_fault_i
    |=> !elastic_buffer_error_flag)
    else $error("Buffer flag not cleared");
  eb_sticky_a: assert property (ce_i && eb_fault_i |=> elastic_buffer_error_flag)
    else $error("Buffer fault lost");
  eb_hold_a: assert property (ce_i && elastic_buffer_error_flag && !eb_fault_i && !wr_i |=> elastic_buffer_error_flag)
    else $error("Buffer flag dropped without clear");
endmodule
`default_nettype wire

/* File: dv/far_side_model.sv */
// Far-side lane model: lane start, multiframe boundaries, octet ticks, buffer faults
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic lanes_en_i,
  input wire logic fault_i,
  output logic all_lanes_writing_o,
  output logic mf_boundary_o,
  output logic quad_octet_tick_o,
  output logic eb_fault_o
);
  logic [2:0] cnt;
  // A tick every cycle keeps release latency exact to predict
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 3'h0;
      all_lanes_writing_o <= 1'b0;
      mf_boundary_o <= 1'b0;
      quad_octet_tick_o <= 1'b0;
      eb_fault_o <= 1'b0;
    end else begin
      cnt <= cnt + 3'h1;
      all_lanes_writing_o <= lanes_en_i;
      mf_boundary_o <= cnt == 3'h7;
      quad_octet_tick_o <= 1'b1;
      eb_fault_o <= fault_i;
    end
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the release and sync configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import jesd_rx_cfg_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, enc = 0, sc = 0, en = 0, flt = 0, ce = 1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wd = '0, rd_data_o, v;
  logic [7:0] f = 8'h04;
  logic [4:0] e = 5'h01;
  logic lanes, mfb, tick, ebf, crc, rsv, rel, ebe;
  logic [MF_W-1:0] mf;
  int err_count = 0, checked = 0, seed = 15615, n, k, kl, kb;
  cfg_t m;
  always #25 clk_sys_i = ~clk_sys_i;
  jesd_rx_release_sync_cfg i_jesd_rx_release_sync_cfg (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ce_i(ce), .addr_i(addr_i), .wr_data_i(wd), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .link_encoding_select_i(enc), .subclass_i(sc),
    .serial_link_enable_i(en), .octets_per_frame_i(f), .multiblocks_per_emb_i(e),
    .all_lanes_writing_i(lanes), .mf_boundary_i(mfb), .quad_octet_tick_i(tick),
    .eb_fault_i(ebf), .crc12_check_en_o(crc), .sync_mode_reserved_o(rsv),
    .multiframe_frames_o(mf), .buffer_release_o(rel), .elastic_buffer_error_flag_o(ebe));
  far_side_model i_far_side_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .lanes_en_i(en),
    .fault_i(flt), .all_lanes_writing_o(lanes), .mf_boundary_o(mfb),
    .quad_octet_tick_o(tick), .eb_fault_o(ebf));
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("ERROR %0t saw %h expected %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wd <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rd_data_o;
  endtask
  task automatic cmp();
    repeat (3) @(posedge clk_sys_i);
    #1 chk(crc, enc && m.sync_header_mode == 2'h0);
    chk(rsv, enc && m.sync_header_mode != 2'h0);
    chk(mf, enc ? 256 * e / f : m.frames_per_multiframe_less_one + 1);
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    m = '{2'h0, 8'h1f, 6'h00};
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(12'h104); chk(v, 8'h00);
    rd(12'h105); chk(v, 8'h1f);
    rd(12'h106); chk(v, 8'h00);
    rd(12'h100); chk(v, 8'h00);
    rd(12'h107); chk(v, 8'h00);
    cmp();
    // Clock enable low freezes every register, so this write must not land
    @(posedge clk_sys_i);
    ce <= 1'b0;
    wr(12'h105, 8'h55);
    ce <= 1'b1;
    rd(12'h105); chk(v, 8'h1f);
    // Settings only move while the link is disabled
    for (n = 0; n < 12; n++) begin
      @(posedge clk_sys_i);
      enc <= n[0];
      e <= 5'((xs() & 7) + 1);
      f <= 8'(1 << (xs() & 3));
      m = cfg_t'(xs());
      if (n < 8) m.sync_header_mode = 2'(n / 2);
      wr(12'h104, {6'h3f, m.sync_header_mode});
      wr(12'h105, m.frames_per_multiframe_less_one);
      wr(12'h106, {2'h3, m.release_buffer_delay});
      rd(12'h104); chk(v, m.sync_header_mode);
      rd(12'h105); chk(v, m.frames_per_multiframe_less_one);
      rd(12'h106); chk(v, m.release_buffer_delay);
      cmp();
    end
    // K=32, F=4 keeps every delay used below legal
    wr(12'h105, 8'h1f);
    for (n = 0; n < 3; n++) begin
      wr(12'h106, 8'(n * 2));
      enc <= 1'b0;
      f <= 8'h04;
      sc <= n != 0;
      en <= 1'b1;
      kl = -1;
      kb = -1;
      for (k = 0; k < 40 && rel !== 1'b1; k++) begin
        @(posedge clk_sys_i);
        #1 if (lanes === 1'b1 && kl < 0) kl = k;
        if (mfb === 1'b1 && kl >= 0 && k > kl && kb < 0) kb = k;
      end
      if (rel !== 1'b1) begin
        // A release that never comes counts as a mismatch
        err_count++;
        break;
      end
      chk(k - 1, n != 0 ? kb + n * 2 + 2 : kl + 1);
      rd(12'h107); chk(v, 8'h40);
      @(posedge clk_sys_i);
      en <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1 chk(rel, 1'b0);
    end
    @(posedge clk_sys_i);
    flt <= 1'b1;
    @(posedge clk_sys_i);
    flt <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1 chk(ebe, 1'b1);
    rd(12'h107); chk(v[7], 1'b1);
    wr(12'h107, 8'h80);
    @(posedge clk_sys_i);
    #1 chk(ebe, 1'b0);
    // A one-cycle fault landing with the clear must win over it
    @(posedge clk_sys_i);
    flt <= 1'b1;
    fork
      wr(12'h107, 8'h80);
      begin
        @(posedge clk_sys_i);
        flt <= 1'b0;
      end
    join
    repeat (3) @(posedge clk_sys_i);
    #1 chk(ebe, 1'b1);
    // Reset in mid-run brings every setting and the flag back to defaults
    wr(12'h105, 8'h07);
    wr(12'h106, 8'h15);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(12'h105); chk(v, 8'h1f);
    rd(12'h106); chk(v, 8'h00);
    rd(12'h104); chk(v, 8'h00);
    rd(12'h107); chk(v, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
